// ### core/dcfifo_mem.sv
// one bit wide storage with a registered read port
`timescale 1ns/1ps
module dcfifo_mem (
    // write port on the write clock
    input wire logic i_wclk,
    input wire logic i_we,
    input wire logic [dcfifo_pkg::AW-1:0] i_waddr,
    input wire logic i_wbit,
    // read port on the read clock
    input wire logic i_rclk,
    input wire logic i_reset,
    input wire logic i_re,
    input wire logic [dcfifo_pkg::AW-1:0] i_raddr,
    output logic o_rbit
);

    logic [dcfifo_pkg::DEPTH-1:0] mem_q;
    logic rbit_q;

    // ========================================================
    // write port, no reset so it maps to plain storage
    always_ff @(posedge i_wclk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wbit; // RL2
        end
    end

    // read data held until the next pop
    always_ff @(posedge i_rclk or posedge i_reset) begin
        if (i_reset) begin
            rbit_q <= 1'b0;
        end else if (i_re) begin
            rbit_q <= mem_q[i_raddr]; // RL1
        end
    end

    assign o_rbit = rbit_q;

    // ========================================================
    chk_pop_oldest_bit: assert property (@(posedge i_rclk) disable iff (i_reset) // RL1
        i_re |=> o_rbit == $past(mem_q[i_raddr]))
        else $error("popped bit differs from stored slot");

endmodule

// ### core/dcfifo_pkg.sv
// constants and pointer helpers for the dual clock one bit fifo
//
// Contract
// RL1 - bits leave in exactly the order written
// RL2 - every stored word is one bit
// RL3 - write and read clocks fully unrelated
// RL4 - both clocks run continuously, not per transfer
// RL5 - enables, not clocks, select transfer cycles
// RL6 - input ready moves only with write clock
// RL7 - output ready moves only with read clock
// RL8 - half full and almost flags use write clock
// RL9 - controller checks flags before each transfer; only the reader model does, the bench writes without checking input ready
// RL10 - write stores bit only while input ready
// RL11 - read pops oldest bit only while output ready
package dcfifo_pkg;

    // ========================================================
    // geometry
    localparam int DEPTH = 64;
    localparam int AW = 6;
    localparam int PW = AW + 1;
    localparam int SYNC_STAGES = 3;
    localparam logic [PW-1:0] DEPTH_LVL = 7'h40;
    localparam logic [PW-1:0] HALF_LVL = 7'h20;
    localparam logic [PW-1:0] PTR_ONE = 7'h01;

    // ========================================================
    // register map on the write clock side
    localparam int ADDR_W = 8;
    localparam int REG_DW = 32;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_THRESH = 8'h08;
    localparam logic [ADDR_W-1:0] REG_LEVEL = 8'h0c;
    localparam logic [AW-1:0] THRESH_RST = 6'h08;
    localparam int LVL_IR_BIT = 8;
    localparam int LVL_HF_BIT = 9;
    localparam int LVL_AB_BIT = 10;

    // ========================================================
    // event bits, same layout in status and mask
    localparam int EV_W = 4;
    localparam int EV_OVERFLOW = 0;
    localparam int EV_HALF = 1;
    localparam int EV_ALMOST = 2;
    localparam int EV_FULL = 3;

    // ========================================================
    // gray helpers for pointer crossing
    function automatic logic [PW-1:0] dcfifo_to_gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] dcfifo_from_gray(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ### core/dcfifo_sync.sv
// multi stage synchroniser for gray coded pointers
`timescale 1ns/1ps
module dcfifo_sync #(
    parameter int W = 7,
    parameter int STAGES = 3
) (
    // destination clock
    input wire logic i_clk,
    input wire logic i_reset,
    // data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    typedef struct packed {
        logic [STAGES-1:0][W-1:0] stage;
    } dcfifo_sync_state_type;

    dcfifo_sync_state_type s_q, s_d;

    // ========================================================
    // shift chain; only stage one reads the first flop
    always_comb begin
        s_d = s_q;
        s_d.stage[0] = i_async;
        for (int i = 1; i < STAGES; i++) begin
            s_d.stage[i] = s_q.stage[i-1];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.stage[STAGES-1];

endmodule

// ### core/dcfifo_top.sv
// dual clock one bit fifo with write side status registers and interrupt
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module dcfifo_top (
    // write clock domain, also clocks the register port
    input wire logic i_clk,
    input wire logic i_reset,
    // read clock domain, free running and unrelated to i_clk
    input wire logic i_read_clock,
    // write side
    input wire logic i_write_enable,
    input wire logic i_write_data,
    output logic o_input_ready,
    output logic o_half_full_flag,
    output logic o_almost_boundary_flag,
    // read side
    input wire logic i_read_enable,
    output logic o_read_data,
    output logic o_output_ready,
    // register port
    input wire logic [dcfifo_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [dcfifo_pkg::REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [dcfifo_pkg::REG_DW-1:0] o_reg_rdata,
    // interrupt
    output logic o_irq
);

    // ========================================================
    // state of the write clock domain
    typedef struct packed {
        logic [dcfifo_pkg::PW-1:0] wbin;
        logic [dcfifo_pkg::PW-1:0] wgray;
        logic [dcfifo_pkg::PW-1:0] level;
        logic input_ready;
        logic half;
        logic almost;
        logic [dcfifo_pkg::EV_W-1:0] status;
        logic [dcfifo_pkg::EV_W-1:0] mask;
        logic [dcfifo_pkg::AW-1:0] thresh;
        logic [dcfifo_pkg::REG_DW-1:0] rdata;
        logic irq;
    } dcfifo_wstate_type;

    // state of the read clock domain
    typedef struct packed {
        logic [dcfifo_pkg::PW-1:0] rbin;
        logic [dcfifo_pkg::PW-1:0] rgray;
        logic output_ready;
    } dcfifo_rstate_type;

    dcfifo_wstate_type wq, wd;
    dcfifo_rstate_type rq, rd;

    logic [dcfifo_pkg::PW-1:0] r2w_gray;
    logic [dcfifo_pkg::PW-1:0] w2r_gray;
    logic push;
    logic pop;
    logic mem_bit;

    // transfers happen only on enable with the matching flag high
    assign push = i_write_enable & wq.input_ready; // RL5 RL10
    assign pop = i_read_enable & rq.output_ready; // RL5 RL11

    // ========================================================
    // pointer crossings; gray code keeps each hop to one bit change
    dcfifo_sync #(
        .W(dcfifo_pkg::PW),
        .STAGES(dcfifo_pkg::SYNC_STAGES)
    ) u_sync_r2w (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(rq.rgray),
        .o_sync(r2w_gray)
    );

    dcfifo_sync #(
        .W(dcfifo_pkg::PW),
        .STAGES(dcfifo_pkg::SYNC_STAGES)
    ) u_sync_w2r (
        .i_clk(i_read_clock),
        .i_reset(i_reset),
        .i_async(wq.wgray),
        .o_sync(w2r_gray)
    );

    // ========================================================
    // storage
    dcfifo_mem u_mem (
        .i_wclk(i_clk),
        .i_we(push),
        .i_waddr(wq.wbin[dcfifo_pkg::AW-1:0]),
        .i_wbit(i_write_data),
        .i_rclk(i_read_clock),
        .i_reset(i_reset),
        .i_re(pop),
        .i_raddr(rq.rbin[dcfifo_pkg::AW-1:0]),
        .o_rbit(mem_bit)
    );

    // ========================================================
    // write domain next state: pointer, flags, registers
    always_comb begin
        logic [dcfifo_pkg::PW-1:0] rbin_seen;
        logic [dcfifo_pkg::PW-1:0] thr;
        logic [dcfifo_pkg::EV_W-1:0] ev;
        logic [dcfifo_pkg::EV_W-1:0] clr;
        rbin_seen = dcfifo_pkg::dcfifo_from_gray(r2w_gray);
        thr = {1'b0, wq.thresh};
        ev = '0;
        clr = '0;
        wd = wq;
        // register writes
        if (i_reg_write) begin
            unique case (i_reg_addr)
                dcfifo_pkg::REG_STATUS: clr = i_reg_wdata[dcfifo_pkg::EV_W-1:0];
                dcfifo_pkg::REG_MASK: wd.mask = i_reg_wdata[dcfifo_pkg::EV_W-1:0];
                dcfifo_pkg::REG_THRESH: wd.thresh = i_reg_wdata[dcfifo_pkg::AW-1:0];
                default: clr = '0;
            endcase
        end
        // new threshold steers the flag at once, so flag and register never disagree
        thr = {1'b0, wd.thresh};
        // advance the write pointer on an accepted write
        if (push) begin
            wd.wbin = wq.wbin + dcfifo_pkg::PTR_ONE; // RL10
        end
        wd.wgray = dcfifo_pkg::dcfifo_to_gray(wd.wbin);
        // fill seen from the write side; read progress arrives late, so
        // the level is pessimistic and never overstates free space
        wd.level = wd.wbin - rbin_seen;
        wd.input_ready = (wd.level != dcfifo_pkg::DEPTH_LVL); // RL6
        wd.half = (wd.level >= dcfifo_pkg::HALF_LVL); // RL8
        wd.almost = (wd.level <= thr) || (wd.level >= dcfifo_pkg::DEPTH_LVL - thr); // RL8
        // events
        ev[dcfifo_pkg::EV_OVERFLOW] = i_write_enable & ~wq.input_ready;
        ev[dcfifo_pkg::EV_HALF] = wd.half & ~wq.half;
        ev[dcfifo_pkg::EV_ALMOST] = wd.almost & ~wq.almost;
        ev[dcfifo_pkg::EV_FULL] = ~wd.input_ready & wq.input_ready;
        // a new event beats a clear in the same cycle
        wd.status = (wq.status & ~clr) | ev;
        wd.irq = |(wd.status & wd.mask);
        // read data live for one cycle only
        wd.rdata = '0;
        if (i_reg_read) begin
            unique case (i_reg_addr)
                dcfifo_pkg::REG_STATUS: wd.rdata[dcfifo_pkg::EV_W-1:0] = wq.status;
                dcfifo_pkg::REG_MASK: wd.rdata[dcfifo_pkg::EV_W-1:0] = wq.mask;
                dcfifo_pkg::REG_THRESH: wd.rdata[dcfifo_pkg::AW-1:0] = wq.thresh;
                dcfifo_pkg::REG_LEVEL: begin
                    wd.rdata[dcfifo_pkg::PW-1:0] = wq.level;
                    wd.rdata[dcfifo_pkg::LVL_IR_BIT] = wq.input_ready;
                    wd.rdata[dcfifo_pkg::LVL_HF_BIT] = wq.half;
                    wd.rdata[dcfifo_pkg::LVL_AB_BIT] = wq.almost;
                end
                default: wd.rdata = '0;
            endcase
        end
    end

    // write domain registers; flags only ever move on i_clk
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wq <= '0;
            wq.input_ready <= 1'b1;
            wq.almost <= 1'b1;
            wq.thresh <= dcfifo_pkg::THRESH_RST;
        end else begin
            wq <= wd; // RL6 RL8
        end
    end

    // ========================================================
    // read domain next state: pointer and output ready
    always_comb begin
        rd = rq;
        if (pop) begin
            rd.rbin = rq.rbin + dcfifo_pkg::PTR_ONE; // RL11 RL1
        end
        rd.rgray = dcfifo_pkg::dcfifo_to_gray(rd.rbin);
        // write progress arrives late, so empty is reported early
        rd.output_ready = (rd.rgray != w2r_gray); // RL7
    end

    // read domain registers, independent of the write clock
    always_ff @(posedge i_read_clock or posedge i_reset) begin
        if (i_reset) begin
            rq <= '0;
        end else begin
            rq <= rd; // RL3 RL7
        end
    end

    // ========================================================
    // outputs, all from flops
    assign o_input_ready = wq.input_ready;
    assign o_half_full_flag = wq.half;
    assign o_almost_boundary_flag = wq.almost;
    assign o_reg_rdata = wq.rdata;
    assign o_irq = wq.irq;
    assign o_output_ready = rq.output_ready;
    assign o_read_data = mem_bit;

    // ========================================================
    // write side checks
    chk_write_enable_gate: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
        !i_write_enable |=> wq.wbin == $past(wq.wbin))
        else $error("write pointer moved without write enable");

    chk_write_refused_full: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
        i_write_enable && !o_input_ready |=> wq.wbin == $past(wq.wbin))
        else $error("write taken while input ready low");

    chk_write_taken_step: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
        i_write_enable && o_input_ready |=> wq.wbin == $past(wq.wbin) + dcfifo_pkg::PTR_ONE)
        else $error("accepted write did not advance by one");

    chk_ready_means_room: assert property (@(posedge i_clk) disable iff (i_reset) // RL6
        o_input_ready |-> (wq.wbin - dcfifo_pkg::dcfifo_from_gray(r2w_gray))
            != dcfifo_pkg::DEPTH_LVL)
        else $error("input ready high while fifo full");

    chk_level_in_range: assert property (@(posedge i_clk) disable iff (i_reset) // RL3
        wq.level <= dcfifo_pkg::DEPTH_LVL)
        else $error("fill level beyond depth");

    chk_half_flag_level: assert property (@(posedge i_clk) disable iff (i_reset) // RL8
        $rose(o_half_full_flag) |-> $past(i_write_enable) && wq.level == dcfifo_pkg::HALF_LVL)
        else $error("half full rose without a write to half depth");

    chk_almost_near_edge: assert property (@(posedge i_clk) disable iff (i_reset) // RL8
        !o_almost_boundary_flag |-> wq.level > {1'b0, wq.thresh}
            && wq.level < dcfifo_pkg::DEPTH_LVL - {1'b0, wq.thresh})
        else $error("almost flag low at a boundary level");

    chk_event_beats_clear: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
        i_write_enable && !o_input_ready |=> wq.status[dcfifo_pkg::EV_OVERFLOW])
        else $error("overflow event lost");

    // read side checks
    chk_read_enable_gate: assert property (@(posedge i_read_clock) disable iff (i_reset) // RL11
        !(i_read_enable && o_output_ready) |=> rq.rbin == $past(rq.rbin)
            && $stable(o_read_data))
        else $error("read side changed without an accepted read");

    chk_read_taken_step: assert property (@(posedge i_read_clock) disable iff (i_reset) // RL11
        i_read_enable && o_output_ready |=> rq.rbin == $past(rq.rbin) + dcfifo_pkg::PTR_ONE)
        else $error("accepted read did not advance by one");

    chk_ready_means_data: assert property (@(posedge i_read_clock) disable iff (i_reset) // RL7
        o_output_ready |-> rq.rgray != w2r_gray)
        else $error("output ready high while fifo empty");

    // main scenarios
    cov_fill_to_full: cover property (@(posedge i_clk) disable iff (i_reset)
        o_input_ready ##1 !o_input_ready);
    cov_write_while_full: cover property (@(posedge i_clk) disable iff (i_reset)
        i_write_enable && !o_input_ready);
    cov_drain_to_empty: cover property (@(posedge i_read_clock) disable iff (i_reset)
        i_read_enable && o_output_ready ##1 !o_output_ready);

endmodule

// ### dv/dcfifo_reader.sv
// reading controller model on the read clock for the one bit fifo
`timescale 1ns/1ps
module dcfifo_reader (
    // read clock domain
    input wire logic i_read_clock,
    input wire logic i_reset,
    // fifo read side
    input wire logic i_output_ready,
    input wire logic i_read_data,
    output logic o_read_enable,
    // bench control
    input wire logic i_go,
    input wire logic i_slow
);
    // ========================================
    // state
    logic pend_q;
    logic [1:0] gap_q;
    logic got[$];

    // pops only after seeing ready; slow mode asks one cycle in four
    always @(posedge i_read_clock or posedge i_reset) begin
        if (i_reset) begin
            pend_q <= 1'b0;
            gap_q <= 2'h0;
            o_read_enable <= 1'b0;
        end else begin
            if (pend_q) begin
                got.push_back(i_read_data);
            end
            pend_q <= o_read_enable && i_output_ready;
            gap_q <= gap_q + 2'h1;
            o_read_enable <= i_go && i_output_ready && (!i_slow || gap_q == 2'h0);
        end
    end
endmodule

// ### dv/tb_dcfifo_top.sv
// self checking bench for the dual clock one bit fifo
`timescale 1ns/1ps
module tb_dcfifo_top;
    // ========================================
    // signals
    logic i_clk, i_reset, i_read_clock, write_enable, write_data, read_enable;
    logic input_ready, half_full, almost, read_data, output_ready, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic reg_write, reg_read, go, slow;
    int mismatches = 0;
    int samples_checked = 0;

    // ========================================
    // clocks, both free running, unrelated in phase and rate
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        i_read_clock = 1'b0;
        #1.3;
        forever #3.35 i_read_clock = ~i_read_clock;
    end

    dcfifo_top i_dcfifo_top (.i_clk(i_clk), .i_reset(i_reset), .i_read_clock(i_read_clock),
        .i_write_enable(write_enable), .i_write_data(write_data),
        .o_input_ready(input_ready), .o_half_full_flag(half_full),
        .o_almost_boundary_flag(almost), .i_read_enable(read_enable),
        .o_read_data(read_data), .o_output_ready(output_ready), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_write(reg_write), .i_reg_read(reg_read),
        .o_reg_rdata(reg_rdata), .o_irq(irq));
    dcfifo_reader i_dcfifo_reader (.i_read_clock(i_read_clock), .i_reset(i_reset),
        .i_output_ready(output_ready), .i_read_data(read_data),
        .o_read_enable(read_enable), .i_go(go), .i_slow(slow));

    // ========================================
    // helpers
    function automatic logic pat(input int i);
        return i[0] ^ i[2] ^ i[5];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge i_clk);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge i_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic fifo_wr(input logic d);
        @(posedge i_clk);
        write_enable <= 1'b1;
        write_data <= d;
        @(posedge i_clk);
        write_enable <= 1'b0;
        #1;
    endtask

    task automatic wait_got(input int n);
        for (int k = 0; k < 3000 && i_dcfifo_reader.got.size() < n; k++) @(posedge i_clk);
    endtask

    // ========================================
    // scenarios
    task automatic test_reset();
        chk({27'h0, input_ready, half_full, almost, output_ready, irq}, 32'h14);
        reg_rd(dcfifo_pkg::REG_STATUS, rd);
        chk(rd, 32'h0);
        reg_rd(dcfifo_pkg::REG_MASK, rd);
        chk(rd, 32'h0);
        reg_rd(dcfifo_pkg::REG_THRESH, rd);
        chk(rd, 32'h8);
        reg_wr(dcfifo_pkg::REG_THRESH, 32'h10);
        reg_rd(dcfifo_pkg::REG_THRESH, rd);
        chk(rd, 32'h10);
        reg_wr(dcfifo_pkg::REG_THRESH, 32'h8);
        reg_wr(dcfifo_pkg::REG_LEVEL, 32'hff); // read only, must be ignored
        reg_rd(dcfifo_pkg::REG_LEVEL, rd);
        chk(rd, 32'h500);
        reg_rd(8'h10, rd);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    // reader runs while bits go in, so both clocks are busy at once
    task automatic test_order();
        go <= 1'b1;
        for (int i = 0; i < 40; i++) fifo_wr(pat(i));
        wait_got(40);
        chk(i_dcfifo_reader.got.size(), 32'd40);
        for (int i = 0; i < 40; i++) chk(i_dcfifo_reader.got[i], pat(i));
        go <= 1'b0;
        repeat (30) @(posedge i_clk);
        i_dcfifo_reader.got.delete();
        reg_wr(dcfifo_pkg::REG_STATUS, 32'hf);
        reg_rd(dcfifo_pkg::REG_STATUS, rd);
        chk(rd, 32'h0);
        $display("test order done");
    endtask

    // reader stalled: exact level lets every flag be predicted
    task automatic test_fill();
        for (int n = 1; n <= 64; n++) begin
            fifo_wr(pat(n - 1));
            chk({29'h0, input_ready, half_full, almost},
                {29'h0, n < 64, n >= 32, (n <= 8) || (n >= 56)});
        end
        fifo_wr(~pat(64)); // refused, not stored
        reg_rd(dcfifo_pkg::REG_LEVEL, rd);
        chk(rd, 32'h640);
        reg_rd(dcfifo_pkg::REG_STATUS, rd);
        chk(rd, 32'hf);
        chk(irq, 1'b0);
        reg_wr(dcfifo_pkg::REG_MASK, 32'h1);
        repeat (2) @(posedge i_clk);
        #1 chk(irq, 1'b1);
        reg_wr(dcfifo_pkg::REG_STATUS, 32'h1);
        repeat (2) @(posedge i_clk);
        #1 chk(irq, 1'b0);
        reg_rd(dcfifo_pkg::REG_STATUS, rd);
        chk(rd, 32'he);
        // refused write and its clear in one cycle: the event must win
        @(posedge i_clk);
        write_enable <= 1'b1;
        reg_addr <= dcfifo_pkg::REG_STATUS;
        reg_wdata <= 32'h1;
        reg_write <= 1'b1;
        @(posedge i_clk);
        write_enable <= 1'b0;
        reg_write <= 1'b0;
        reg_rd(dcfifo_pkg::REG_STATUS, rd);
        chk(rd, 32'hf);
        chk(irq, 1'b1);
        slow <= 1'b1;
        go <= 1'b1;
        wait_got(64);
        repeat (60) @(posedge i_clk);
        chk(i_dcfifo_reader.got.size(), 32'd64);
        for (int i = 0; i < 64; i++) chk(i_dcfifo_reader.got[i], pat(i));
        chk({29'h0, input_ready, half_full, almost, output_ready}, 32'ha);
        $display("test fill done");
    endtask

    // ========================================
    // verdict, reached by the main sequence or the watchdog
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #60000;
        mismatches++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        i_reset = 1'b1;
        {write_enable, write_data, reg_write, reg_read, go, slow} = 6'h0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        test_reset();
        test_order();
        test_fill();
        conclude();
    end
endmodule
